// [clock_ctl_defines.svh]
`ifndef CLOCK_CTL_DEFINES_SVH
`define CLOCK_CTL_DEFINES_SVH
`define SMB_ADDR_WR    8'hD2
`define SMB_CMD_CODE   8'h00
`define SMB_COUNT_MAX  8'h20
`define SMB_IDX_W      5
`define CTRL_IDX       5'h00
`define CTRL_RESET     8'h00
`define CTRL_WR_MASK   8'hA8
`define CTRL_SPREAD    7
`define CTRL_VCH_SEL   5
`define CTRL_SW_PCISTP 3
`define FSEL_TEST      2'h1
`define SYNC_W         12
`define SYNC_IDLE      12'h078
`endif

// [clock_ctl_pkg.sv]
package clock_ctl_pkg;
  typedef enum logic [1:0] {
    MODE_INTERNAL = 2'b00,
    MODE_EXT66    = 2'b01,
    MODE_HIZ      = 2'b10,
    MODE_TEST     = 2'b11
  } clk_mode_t;
  typedef enum logic [2:0] {
    SMB_IDLE   = 3'b000,
    SMB_ADDR   = 3'b001,
    SMB_CMD    = 3'b010,
    SMB_COUNT  = 3'b011,
    SMB_DATA   = 3'b100,
    SMB_IGNORE = 3'b101
  } smb_state_t;
endpackage : clock_ctl_pkg

// [smbus_wr_if.sv]
`timescale 1ns/1ns
`include "clock_ctl_defines.svh"
interface smbus_wr_if;
  logic                  wr_valid;
  logic [`SMB_IDX_W-1:0] wr_index;
  logic [7:0]            wr_data;
  modport src (output wr_valid, output wr_index, output wr_data);
  modport dst (input wr_valid, input wr_index, input wr_data);
endinterface : smbus_wr_if

// [smbus_block_write_slave.sv]
`timescale 1ns/1ns
`include "clock_ctl_defines.svh"
module smbus_block_write_slave (
  // system
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // serial pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_oe_q,
  // byte writes to the register file
  smbus_wr_if.src   wr
);
  logic [1:0] scl_s_q, sda_s_q;
  logic       scl_p_q, sda_p_q;
  clock_ctl_pkg::smb_state_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, left_q, left_d;
  logic       ack_q, ack_d, oe_d, done_q, done_d, acked_q, acked_d;
  logic [`SMB_IDX_W-1:0] idx_q, idx_d;
  logic       wv_d;
  logic [7:0] byte_v;
  logic       scl_rise, scl_fall, start_c, stop_c;

  // first stage feeds the second only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end

  assign scl_rise = scl_s_q[1] & ~scl_p_q;
  assign scl_fall = ~scl_s_q[1] & scl_p_q;
  assign start_c  = scl_s_q[1] & scl_p_q & ~sda_s_q[1] & sda_p_q;
  assign stop_c   = scl_s_q[1] & scl_p_q & sda_s_q[1] & ~sda_p_q;
  assign byte_v   = {sh_q[6:0], sda_s_q[1]};

  always_comb begin
    st_d    = st_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    left_d  = left_q;
    ack_d   = ack_q;
    oe_d    = sda_oe_q;
    done_d  = done_q;
    acked_d = acked_q;
    idx_d   = idx_q;
    wv_d    = 1'b0;
    if (stop_c) begin
      st_d = clock_ctl_pkg::SMB_IDLE;
      oe_d = 1'b0;
      ack_d = 1'b0;
    end else if (start_c) begin
      st_d    = clock_ctl_pkg::SMB_ADDR;
      bit_d   = 4'h0;
      ack_d   = 1'b0;
      done_d  = 1'b0;
      oe_d    = 1'b0;
    end else if (scl_rise && !ack_q && !done_q && st_q != clock_ctl_pkg::SMB_IDLE) begin
      sh_d  = byte_v;
      bit_d = bit_q + 4'h1;
      if (bit_q == 4'h7) begin
        done_d  = 1'b1;
        acked_d = 1'b1;
        unique case (st_q)
          clock_ctl_pkg::SMB_ADDR: begin
            if (byte_v == `SMB_ADDR_WR) st_d = clock_ctl_pkg::SMB_CMD;
            else acked_d = 1'b0;
          end
          clock_ctl_pkg::SMB_CMD: begin
            if (byte_v == `SMB_CMD_CODE) st_d = clock_ctl_pkg::SMB_COUNT;
            else acked_d = 1'b0;
          end
          clock_ctl_pkg::SMB_COUNT: begin
            // an out-of-range count gets no data accepted
            left_d = (byte_v > `SMB_COUNT_MAX) ? 8'h00 : byte_v;
            idx_d  = '0;
            st_d   = clock_ctl_pkg::SMB_DATA;
          end
          clock_ctl_pkg::SMB_DATA: begin
            if (left_q != 8'h00) begin
              wv_d   = 1'b1;
              idx_d  = idx_q + `SMB_IDX_W'(1);
              left_d = left_q - 8'h01;
            end else acked_d = 1'b0;
          end
          clock_ctl_pkg::SMB_IGNORE: acked_d = 1'b0;
          default: acked_d = 1'b0;
        endcase
        if (!acked_d && st_q != clock_ctl_pkg::SMB_IGNORE) st_d = clock_ctl_pkg::SMB_IGNORE;
      end
    end else if (scl_fall) begin
      if (ack_q) begin
        ack_d = 1'b0;
        oe_d  = 1'b0;
        bit_d = 4'h0;
      end else if (done_q) begin
        done_d = 1'b0;
        ack_d  = acked_q;
        oe_d   = acked_q;
        if (!acked_q) bit_d = 4'h0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q     <= clock_ctl_pkg::SMB_IDLE;
      bit_q    <= 4'h0;
      sh_q     <= 8'h00;
      left_q   <= 8'h00;
      ack_q    <= 1'b0;
      sda_oe_q <= 1'b0;
      done_q   <= 1'b0;
      acked_q  <= 1'b0;
      idx_q    <= '0;
      wr.wr_valid <= 1'b0;
      wr.wr_index <= '0;
      wr.wr_data  <= 8'h00;
    end else begin
      st_q     <= st_d;
      bit_q    <= bit_d;
      sh_q     <= sh_d;
      left_q   <= left_d;
      ack_q    <= ack_d;
      sda_oe_q <= oe_d;
      done_q   <= done_d;
      acked_q  <= acked_d;
      idx_q    <= idx_d;
      wr.wr_valid <= wv_d;
      wr.wr_index <= idx_q;
      wr.wr_data  <= byte_v;
    end
  end
endmodule : smbus_block_write_slave

// [clock_mode_and_smbus_control.sv]
`timescale 1ns/1ns
`include "clock_ctl_defines.svh"
module clock_mode_and_smbus_control (
  // system
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // straps
  input  wire logic       mode_strap_hi,
  input  wire logic       mode_strap_mid,
  input  wire logic       freq_strap_hi,
  input  wire logic       freq_strap_lo,
  input  wire logic       swing_mult_sel,
  input  wire logic       strap_valid_n,
  // power management pins
  input  wire logic       powerdown_n,
  input  wire logic       host_stop_n,
  input  wire logic       pci_stop_n,
  // clock sources
  input  wire logic       crystal_in,
  input  wire logic       test_clock_in,
  input  wire logic       ext_66_input,
  // smbus
  input  wire logic       smb_scl,
  input  wire logic       smb_sda_in,
  output logic            smb_sda_out,
  output logic            smb_sda_oe,
  // host clock outputs
  output logic            host_clk,
  output logic            host_clk_n,
  output logic            host_clk_n_oe,
  output logic            host_current_ref_x2,
  output logic [1:0]      host_freq_sel,
  // other clock outputs
  output logic            fixed_66_out,
  output logic            video_hub_clk,
  output logic [2:0]      buffered_66_out,
  output logic            shared_66_out,
  output logic            shared_66_oe,
  output logic [2:0]      pci_f_out,
  output logic [6:0]      pci_out,
  output logic            usb_48_out,
  output logic            dot_48_out,
  output logic            ref_out,
  // status and analog controls
  output logic            clk_out_oe,
  output logic            osc_vco_on,
  output logic            spread_on,
  output logic            swing_mult_q,
  output logic [7:0]      ctrl_byte_rd
);
  smbus_wr_if wr_bus ();

  logic [`SYNC_W-1:0] s1_q, s2_q;
  logic               ext_p_q, tck_p_q;
  logic [4:0]         strap_q, strap_d;
  logic               latched_q, latched_d;
  logic [7:0]         ctrl_q, ctrl_d;
  logic [2:0]         phase_q, phase_d;
  clock_ctl_pkg::clk_mode_t mode_c;
  logic pd_s, hstop_s, pstop_s, xtal_s, tck_s, ext_s, vld_s;
  logic tick, lvl_host, lvl_66, lvl_pci, lvl_48, lvl_ref, pci_stopped;
  logic sda_oe_int;
  logic o_host, o_host_n, o_host_n_oe, o_current_ref, o_f66, o_vch, o_sh, o_sh_oe;
  logic o_usb, o_ref, o_oe, o_osc, o_pcif, o_pci, o_b66;

  function automatic clock_ctl_pkg::clk_mode_t decode_mode(input logic hi,
                                                           input logic mid,
                                                           input logic [1:0] fsel);
    // reserved mid-level codes are parked like the off code
    if (mid) decode_mode = (fsel == `FSEL_TEST) ? clock_ctl_pkg::MODE_TEST
                                                : clock_ctl_pkg::MODE_HIZ;
    else if (hi) decode_mode = clock_ctl_pkg::MODE_EXT66;
    else decode_mode = clock_ctl_pkg::MODE_INTERNAL;
  endfunction : decode_mode

  // pins and foreign clocks are synchronised before use
  // sync resets to idle pin levels, else a false strobe latches zero straps
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_q    <= `SYNC_IDLE;
      s2_q    <= `SYNC_IDLE;
      ext_p_q <= 1'b0;
      tck_p_q <= 1'b0;
    end else begin
      s1_q    <= {mode_strap_hi, mode_strap_mid, freq_strap_hi, freq_strap_lo,
                  swing_mult_sel, strap_valid_n, powerdown_n, host_stop_n,
                  pci_stop_n, crystal_in, test_clock_in, ext_66_input};
      s2_q    <= s1_q;
      ext_p_q <= s2_q[0];
      tck_p_q <= s2_q[1];
    end
  end

  assign vld_s   = ~s2_q[6];
  assign pd_s    = ~s2_q[5];
  assign hstop_s = s2_q[4];
  assign pstop_s = s2_q[3];
  assign xtal_s  = s2_q[2];
  assign tck_s   = s2_q[1];
  assign ext_s   = s2_q[0];

  smbus_block_write_slave u_slave (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .scl_in   (smb_scl),
    .sda_in   (smb_sda_in),
    .sda_oe_q (sda_oe_int),
    .wr       (wr_bus.src)
  );

  // strap capture and control byte
  always_comb begin
    strap_d   = strap_q;
    latched_d = latched_q;
    ctrl_d    = ctrl_q;
    if (!latched_q && vld_s) begin
      strap_d   = s2_q[11:7];
      latched_d = 1'b1;
    end
    if (wr_bus.wr_valid && wr_bus.wr_index == `CTRL_IDX) begin
      ctrl_d = (ctrl_q & ~`CTRL_WR_MASK) | (wr_bus.wr_data & `CTRL_WR_MASK);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      strap_q   <= 5'h00;
      latched_q <= 1'b0;
      ctrl_q    <= `CTRL_RESET;
    end else begin
      strap_q   <= strap_d;
      latched_q <= latched_d;
      ctrl_q    <= ctrl_d;
    end
  end

  assign mode_c = decode_mode(strap_q[4], strap_q[3], strap_q[2:1]);

  // phase counter stands in for the divider chain
  always_comb begin
    unique case (mode_c)
      clock_ctl_pkg::MODE_EXT66: tick = ext_s & ~ext_p_q;
      clock_ctl_pkg::MODE_TEST:  tick = tck_s & ~tck_p_q;
      clock_ctl_pkg::MODE_INTERNAL, clock_ctl_pkg::MODE_HIZ: tick = 1'b1;
    endcase
    phase_d = (tick && !pd_s) ? phase_q + 3'h1 : phase_q;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) phase_q <= 3'h0;
    else phase_q <= phase_d;
  end

  // output selection and gating
  always_comb begin
    lvl_host = phase_q[0];
    lvl_48   = phase_q[0];
    lvl_66   = phase_q[0];
    lvl_pci  = phase_q[1];
    lvl_ref  = xtal_s;
    o_sh_oe  = 1'b1;
    unique case (mode_c)
      clock_ctl_pkg::MODE_EXT66: begin
        lvl_66  = ext_s;
        lvl_pci = phase_q[0];
        o_sh_oe = 1'b0;
      end
      clock_ctl_pkg::MODE_TEST: begin
        lvl_ref = tck_s;
        lvl_66  = phase_q[1];
        lvl_pci = phase_q[2];
      end
      clock_ctl_pkg::MODE_INTERNAL, clock_ctl_pkg::MODE_HIZ: begin
        lvl_66 = phase_q[0];
      end
    endcase
    o_oe = latched_q && mode_c != clock_ctl_pkg::MODE_HIZ;
    pci_stopped = ~pstop_s | ctrl_q[`CTRL_SW_PCISTP];
    o_osc       = ~pd_s;
    o_current_ref      = pd_s;
    o_host      = pd_s ? 1'b1 : lvl_host;
    o_host_n    = pd_s ? 1'b0 : ~lvl_host;
    o_host_n_oe = ~pd_s;
    if (!pd_s && !hstop_s) begin
      o_host_n    = 1'b0;
      o_host_n_oe = pstop_s;
    end
    o_f66  = pd_s ? 1'b0 : lvl_66;
    o_b66  = o_f66;
    o_sh   = o_f66;
    o_usb  = pd_s ? 1'b0 : lvl_48;
    o_vch  = ctrl_q[`CTRL_VCH_SEL] ? o_usb : o_f66;
    o_ref  = pd_s ? 1'b0 : lvl_ref;
    o_pcif = pd_s ? 1'b0 : lvl_pci;
    o_pci  = (pd_s || pci_stopped) ? 1'b0 : lvl_pci;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      host_clk        <= 1'b0;
      host_clk_n      <= 1'b0;
      host_clk_n_oe   <= 1'b0;
      host_current_ref_x2    <= 1'b0;
      host_freq_sel   <= 2'h0;
      fixed_66_out    <= 1'b0;
      video_hub_clk   <= 1'b0;
      buffered_66_out <= 3'h0;
      shared_66_out   <= 1'b0;
      shared_66_oe    <= 1'b0;
      pci_f_out       <= 3'h0;
      pci_out         <= 7'h00;
      usb_48_out      <= 1'b0;
      dot_48_out      <= 1'b0;
      ref_out         <= 1'b0;
      clk_out_oe      <= 1'b0;
      osc_vco_on      <= 1'b0;
      spread_on       <= 1'b0;
      swing_mult_q    <= 1'b0;
      ctrl_byte_rd    <= 8'h00;
      smb_sda_oe      <= 1'b0;
    end else begin
      host_clk        <= o_host;
      host_clk_n      <= o_host_n;
      host_clk_n_oe   <= o_host_n_oe & o_oe;
      host_current_ref_x2    <= o_current_ref;
      host_freq_sel   <= strap_q[2:1];
      fixed_66_out    <= o_f66;
      video_hub_clk   <= o_vch;
      buffered_66_out <= {3{o_b66}};
      shared_66_out   <= o_sh;
      shared_66_oe    <= o_sh_oe & o_oe;
      pci_f_out       <= {3{o_pcif}};
      pci_out         <= {7{o_pci}};
      usb_48_out      <= o_usb;
      dot_48_out      <= o_usb;
      ref_out         <= o_ref;
      clk_out_oe      <= o_oe;
      osc_vco_on      <= o_osc;
      spread_on       <= ctrl_q[`CTRL_SPREAD];
      swing_mult_q    <= strap_q[0];
      ctrl_byte_rd    <= {ctrl_q[7], 1'b0, ctrl_q[5], hstop_s, ctrl_q[3],
                          strap_q[4], strap_q[2], strap_q[1]};
      smb_sda_oe      <= sda_oe_int;
    end
  end

  // open drain: only ever pulls low
  assign smb_sda_out = 1'b0;
endmodule : clock_mode_and_smbus_control

// [clock_ctl_assertions.sv]
`timescale 1ns/1ns
module clock_ctl_checker (
  // system
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // straps and pins
  input wire logic       mode_strap_mid,
  input wire logic       freq_strap_hi,
  input wire logic       freq_strap_lo,
  input wire logic       powerdown_n,
  input wire logic       host_stop_n,
  input wire logic       pci_stop_n,
  // watched outputs
  input wire logic       host_clk_n,
  input wire logic       host_clk_n_oe,
  input wire logic       host_current_ref_x2,
  input wire logic [1:0] host_freq_sel,
  input wire logic [6:0] pci_out,
  input wire logic       clk_out_oe,
  input wire logic       osc_vco_on,
  input wire logic       spread_on,
  input wire logic [7:0] ctrl_byte_rd
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // five cycles cover the two-flop pin sync plus the output register
  AST_PWRDN: assert property ((!powerdown_n && clk_out_oe) [*5] |->
    host_current_ref_x2 && !host_clk_n_oe && !osc_vco_on && pci_out == 7'h00)
    else $error("power-down outputs wrong");
  AST_HSTOP_LOW: assert property (
    (powerdown_n && !host_stop_n && pci_stop_n && clk_out_oe) [*5] |-> host_clk_n_oe && !host_clk_n)
    else $error("stopped complement not driven low");
  AST_HSTOP_FLOAT: assert property (
    (powerdown_n && !host_stop_n && !pci_stop_n && clk_out_oe) [*5] |-> !host_clk_n_oe)
    else $error("stopped complement not floating");
  AST_PSTOP: assert property ((powerdown_n && !pci_stop_n) [*5] |-> $stable(pci_out))
    else $error("pci clocks run under pin stop");
  AST_SWSTOP: assert property (ctrl_byte_rd[3] [*5] |-> $stable(pci_out))
    else $error("pci clocks run under software stop");
  AST_SPREAD: assert property (spread_on == ctrl_byte_rd[7])
    else $error("spread output differs from control bit");
  AST_HSTOP_BIT: assert property ($stable(host_stop_n) [*5] |-> ctrl_byte_rd[4] == host_stop_n)
    else $error("host stop readback wrong");
  AST_STRAP_HOLD: assert property (clk_out_oe && $past(clk_out_oe) |->
    $stable(ctrl_byte_rd[2:0]) && $stable(host_freq_sel))
    else $error("latched straps changed");
  AST_HIZ: assert property ((mode_strap_mid && !freq_strap_hi && !freq_strap_lo) [*6] |->
    !clk_out_oe) else $error("outputs enabled in high impedance mode");
endmodule : clock_ctl_checker
bind clock_mode_and_smbus_control clock_ctl_checker clock_ctl_checker_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .mode_strap_mid(mode_strap_mid),
  .freq_strap_hi(freq_strap_hi), .freq_strap_lo(freq_strap_lo), .powerdown_n(powerdown_n),
  .host_stop_n(host_stop_n), .pci_stop_n(pci_stop_n), .host_clk_n(host_clk_n),
  .host_clk_n_oe(host_clk_n_oe), .host_current_ref_x2(host_current_ref_x2), .host_freq_sel(host_freq_sel),
  .pci_out(pci_out), .clk_out_oe(clk_out_oe), .osc_vco_on(osc_vco_on),
  .spread_on(spread_on), .ctrl_byte_rd(ctrl_byte_rd));

// [smbus_host_model.sv]
`timescale 1ns/1ns
module smbus_host_model #(
  parameter int HALF = 10
) (
  // system
  input  wire logic clk_sys,
  // bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // data moves only two cycles after scl falls, so the slave never sees it change while high
  task automatic bit_io(input logic b, output logic s);
    sda_low <= !b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    s = sda;
    scl <= 1'b0;
    tick(2);
  endtask : bit_io
  task automatic start_bit();
    tick(1);
    sda_low <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(2);
  endtask : start_bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : send_byte
  task automatic stop_bit();
    sda_low <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_low <= 1'b0;
    tick(HALF);
  endtask : stop_bit
endmodule : smbus_host_model

// [clock_mode_and_smbus_control_test.sv]
`timescale 1ns/1ns
module clock_mode_and_smbus_control_test;
  logic       clk_sys, reset_n, mode_strap_hi, mode_strap_mid, freq_strap_hi, freq_strap_lo;
  logic       swing_mult_sel, strap_valid_n, powerdown_n, host_stop_n, pci_stop_n, mv_clr;
  logic       crystal_in, test_clock_in, ext_66_input, sda_low, smb_scl, smb_sda_oe;
  logic       host_clk, host_clk_n_oe, host_current_ref_x2, fixed_66_out, ref_out, shared_66_oe;
  logic       clk_out_oe, osc_vco_on, spread_on;
  logic       host_clk_n, video_hub_clk, shared_66_out, usb_48_out, dot_48_out, swing_mult_q;
  logic [1:0] host_freq_sel;
  logic [2:0] buffered_66_out, pci_f_out;
  logic [6:0] pci_out;
  logic [7:0] ctrl_byte_rd;
  logic [5:0] prev_w, moved;
  logic [4:0] ackv;
  int         err_total, check_count, cyc;
  wire        sda = !(sda_low || smb_sda_oe);
  wire [5:0]  watch = {pci_out[0], pci_f_out[0], host_clk, ref_out, buffered_66_out[0], fixed_66_out};
  localparam logic [23:0]  CFGS = {4'h0, 4'h2, 4'h9, 4'hB, 4'h5, 4'h4};
  localparam logic [119:0] BAD  = {24'hD40001, 24'hD30001, 24'hD20101, 24'hD20000, 24'hD20021};
  localparam logic [19:0]  BACK = {4'h0, 4'h0, 4'h8, 4'hE, 4'hE};

  clock_mode_and_smbus_control clock_mode_and_smbus_control_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .mode_strap_hi(mode_strap_hi),
    .mode_strap_mid(mode_strap_mid), .freq_strap_hi(freq_strap_hi),
    .freq_strap_lo(freq_strap_lo), .swing_mult_sel(swing_mult_sel),
    .strap_valid_n(strap_valid_n), .powerdown_n(powerdown_n), .host_stop_n(host_stop_n),
    .pci_stop_n(pci_stop_n), .crystal_in(crystal_in), .test_clock_in(test_clock_in),
    .ext_66_input(ext_66_input), .smb_scl(smb_scl), .smb_sda_in(sda), .smb_sda_out(),
    .smb_sda_oe(smb_sda_oe), .host_clk(host_clk), .host_clk_n(host_clk_n),
    .host_clk_n_oe(host_clk_n_oe), .host_current_ref_x2(host_current_ref_x2), .host_freq_sel(host_freq_sel),
    .fixed_66_out(fixed_66_out), .video_hub_clk(video_hub_clk),
    .buffered_66_out(buffered_66_out), .shared_66_out(shared_66_out),
    .shared_66_oe(shared_66_oe), .pci_f_out(pci_f_out), .pci_out(pci_out),
    .usb_48_out(usb_48_out), .dot_48_out(dot_48_out), .ref_out(ref_out),
    .clk_out_oe(clk_out_oe), .osc_vco_on(osc_vco_on), .spread_on(spread_on),
    .swing_mult_q(swing_mult_q), .ctrl_byte_rd(ctrl_byte_rd));
  smbus_host_model smbus_host_model_i (
    .clk_sys(clk_sys), .sda(sda), .scl(smb_scl), .sda_low(sda_low));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // slow source clocks, well under half the system rate, plus activity tracking
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 0) crystal_in <= !crystal_in;
    if (cyc % 5 == 0) test_clock_in <= !test_clock_in;
    if (cyc % 3 == 0) ext_66_input <= !ext_66_input;
    prev_w <= watch;
    moved  <= mv_clr ? 6'h00 : moved | (watch ^ prev_w);
    if (cyc == 40000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic boot(input logic [3:0] cfg);
    {mode_strap_hi, mode_strap_mid, freq_strap_hi, freq_strap_lo} <= cfg;
    swing_mult_sel <= cfg[0];
    strap_valid_n <= 1'b1;
    reset_n       <= 1'b0;
    tick(4);
    reset_n       <= 1'b1;
    tick(2);
    strap_valid_n <= 1'b0;
    tick(8);
    strap_valid_n <= 1'b1;
    // late strap moves must be ignored; mid mode is never given a reserved code
    {freq_strap_hi, freq_strap_lo} <= cfg[2] ? cfg[1:0] : ~cfg[1:0];
    swing_mult_sel <= !cfg[0];
    tick(8);
  endtask : boot
  task automatic run_chk(input logic [5:0] mask, input logic [5:0] exp);
    tick(8);
    mv_clr <= 1'b1;
    tick(1);
    mv_clr <= 1'b0;
    tick(96);
    chk(moved & mask, exp);
  endtask : run_chk
  task automatic wr(input logic [39:0] b, input int nb);
    logic a;
    ackv = 5'h00;
    smbus_host_model_i.start_bit();
    for (int i = 0; i < nb; i++) begin
      smbus_host_model_i.send_byte(b[39-8*i -: 8], a);
      ackv = {ackv[3:0], a};
    end
    smbus_host_model_i.stop_bit();
    tick(10);
  endtask : wr

  initial begin
    {mode_strap_hi, mode_strap_mid, freq_strap_hi, freq_strap_lo, swing_mult_sel} = '0;
    {crystal_in, test_clock_in, ext_66_input, mv_clr, reset_n} = '0;
    {strap_valid_n, powerdown_n, host_stop_n, pci_stop_n} = '1;
    for (int k = 0; k < 6; k++) begin
      logic [3:0] c;
      c = CFGS[23-4*k -: 4];
      boot(c);
      chk({host_freq_sel, swing_mult_q}, {c[1:0], c[0]});
      chk(clk_out_oe, c[2:0] != 3'b100);
      chk(ctrl_byte_rd & 8'hFB, {6'h04, c[1:0]});
      if (!c[2]) chk({ctrl_byte_rd[2], shared_66_oe}, {c[3], !c[3]});
      if (c[2:0] != 3'b100) run_chk(6'h3F, 6'h3F);
    end
    boot(4'h0);
    wr({8'hD2, 8'h00, 8'h01, 8'hA8, 8'h00}, 4);
    chk({ackv, ctrl_byte_rd}, {5'h0F, 8'hB8});
    chk(spread_on, 1'b1);
    run_chk(6'h3F, 6'h1F);
    wr({8'hD2, 8'h00, 8'h01, 8'hFF, 8'h00}, 4);
    chk(ctrl_byte_rd, 8'hB8);
    wr({8'hD2, 8'h00, 8'h03, 8'h20, 8'h77}, 5);
    chk({ackv, ctrl_byte_rd}, {5'h1F, 8'h30});
    wr({8'hD2, 8'h00, 8'h02, 8'h00, 8'h00}, 3);
    chk({ackv, ctrl_byte_rd}, {5'h07, 8'h30});
    wr({8'hD2, 8'h00, 8'h01, 8'h80, 8'h44}, 5);
    chk({ackv, ctrl_byte_rd}, {5'h1E, 8'h90});
    for (int k = 0; k < 5; k++) begin
      wr({BAD[119-24*k -: 24], 16'h0000}, 4);
      chk({ackv, ctrl_byte_rd}, {1'b0, BACK[19-4*k -: 4], 8'h90});
    end
    host_stop_n <= 1'b0;
    run_chk(6'h3F, 6'h3F);
    chk({host_clk_n_oe, host_clk_n, ctrl_byte_rd}, {2'b10, 8'h80});
    pci_stop_n <= 1'b0;
    run_chk(6'h3F, 6'h1F);
    chk(host_clk_n_oe, 1'b0);
    {host_stop_n, pci_stop_n, powerdown_n} <= 3'b110;
    run_chk(6'h3B, 6'h00);
    chk({host_current_ref_x2, host_clk_n_oe, osc_vco_on, host_clk, usb_48_out, dot_48_out,
         video_hub_clk, shared_66_out}, 8'h90);
    stop_test();
  end
endmodule : clock_mode_and_smbus_control_test
